/* logic/sfpi_consts.vh */
// constants of the serial flash pin interface front end
`ifndef SFPI_CONSTS_VH
`define SFPI_CONSTS_VH
// ------------------------------------------------------------
// synchroniser bit positions
// ------------------------------------------------------------
`define SFPI_IN_SCK      0
`define SFPI_IN_CS_N     1
`define SFPI_IN_SI       2
`define SFPI_IN_PAUSE_N  3
`define SFPI_IN_WP_N     4
`define SFPI_IN_W        5
// chip select resets low: a pin held low from power-up shows no falling edge
`define SFPI_IN_RST      5'h1D
// ------------------------------------------------------------
// byte framing and reset values
// ------------------------------------------------------------
`define SFPI_LAST_BIT    3'h7
`define SFPI_TX_IDLE     8'hFF
// ------------------------------------------------------------
// protection map
// ------------------------------------------------------------
`define SFPI_ADDR_W      21
`define SFPI_ARRAY_TOP   22'h200000
`define SFPI_SECTOR_SIZE 22'h010000
`define SFPI_BP_ALL      3'h6
`endif

/* logic/sfpi_top.v */
// serial flash pin interface front end, device side
`timescale 1ns/1ps
`include "sfpi_consts.vh"
module sfpi_top (
   input  wire                    clk_sys_i,
   input  wire                    rst_n_i,
   input  wire                    sck_i,
   input  wire                    chip_select_n_i,
   input  wire                    serial_data_in_i,
   input  wire                    pause_n_i,
   input  wire                    write_protect_n_i,
   output reg                     serial_data_out_o,
   output reg                     serial_data_out_oe_o,
   input  wire [7:0]              tx_data_i,
   output reg                     tx_load_o,
   output reg  [7:0]              rx_data_o,
   output reg                     rx_valid_o,
   input  wire                    rx_ready_i,
   output reg                     rx_overrun_o,
   output reg                     frame_end_o,
   input  wire                    cmd_write_i,
   input  wire                    cmd_array_i,
   input  wire                    cmd_bulk_i,
   input  wire [`SFPI_ADDR_W-1:0] cmd_addr_i,
   input  wire [2:0]              block_protect_bits_i,
   input  wire                    busy_i,
   output reg                     exec_o,
   output reg                     refuse_o,
   output reg                     selected_o,
   output reg                     standby_o
);

   // ------------------------------------------------------------
   // protection decode
   // ------------------------------------------------------------
   function prot_hit;
      input [2:0]              bp;
      input [`SFPI_ADDR_W-1:0] addr;
      input                    bulk;
      reg   [21:0]             base;
      begin
         base = `SFPI_ARRAY_TOP - (`SFPI_SECTOR_SIZE << (bp - 3'h1));
         if (bp == 3'h0)
            prot_hit = 1'b0;
         else if (bp >= `SFPI_BP_ALL || bulk)
            prot_hit = 1'b1;
         else
            prot_hit = ({1'b0, addr} >= base);
      end
   endfunction

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   reg [4:0] sync1;
   reg [4:0] sync2;
   reg [4:0] prev;
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         sync1 <= `SFPI_IN_RST;
         sync2 <= `SFPI_IN_RST;
         prev  <= `SFPI_IN_RST;
      end else begin
         // only sync2 feeds the edge stage and the logic
         sync1 <= {write_protect_n_i, pause_n_i, serial_data_in_i, chip_select_n_i, sck_i};
         sync2 <= sync1;
         prev  <= sync2;
      end
   end

   wire cs_low    = !sync2[`SFPI_IN_CS_N];
   wire cs_fall   = prev[`SFPI_IN_CS_N] && cs_low;
   wire cs_rise   = !prev[`SFPI_IN_CS_N] && !cs_low;
   wire paused    = !sync2[`SFPI_IN_PAUSE_N];
   wire sck_rise  = !prev[`SFPI_IN_SCK] && sync2[`SFPI_IN_SCK];
   wire sck_fall  = prev[`SFPI_IN_SCK] && !sync2[`SFPI_IN_SCK];
   wire wp_low    = !sync2[`SFPI_IN_WP_N];

   // ------------------------------------------------------------
   // serial shift engine
   // ------------------------------------------------------------
   reg       armed;
   reg       in_frame;
   reg [2:0] bit_cnt;
   reg [7:0] rx_shift;
   reg [7:0] tx_shift;
   reg       seen_rise;
   reg       byte_seen;
   reg       push;
   reg [7:0] push_data;

   // pause freezes the engine but keeps the frame open
   wire live    = in_frame && !paused;
   wire do_rise = live && sck_rise;
   // a falling edge with no rising edge before it (mode 3 start) shifts nothing
   wire do_fall = live && sck_fall && seen_rise;

   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         armed                <= 1'b0;
         in_frame             <= 1'b0;
         bit_cnt              <= 3'h0;
         rx_shift             <= 8'h00;
         tx_shift             <= `SFPI_TX_IDLE;
         seen_rise            <= 1'b0;
         byte_seen            <= 1'b0;
         push                 <= 1'b0;
         push_data            <= 8'h00;
         tx_load_o            <= 1'b0;
         serial_data_out_o    <= 1'b1;
         serial_data_out_oe_o <= 1'b0;
         frame_end_o          <= 1'b0;
      end else begin
         push        <= 1'b0;
         tx_load_o   <= 1'b0;
         frame_end_o <= 1'b0;
         if (cs_fall) begin
            armed             <= 1'b1;
            in_frame          <= 1'b1;
            bit_cnt           <= 3'h0;
            seen_rise         <= 1'b0;
            byte_seen         <= 1'b0;
            tx_shift          <= {tx_data_i[6:0], 1'b1};
            serial_data_out_o <= tx_data_i[7];
            tx_load_o         <= 1'b1;
         end else if (!cs_low) begin
            in_frame    <= 1'b0;
            frame_end_o <= in_frame;
         end else if (do_rise) begin
            rx_shift  <= {rx_shift[6:0], sync2[`SFPI_IN_SI]};
            bit_cnt   <= bit_cnt + 3'h1;
            seen_rise <= 1'b1;
            if (bit_cnt == `SFPI_LAST_BIT) begin
               push      <= 1'b1;
               push_data <= {rx_shift[6:0], sync2[`SFPI_IN_SI]};
               byte_seen <= 1'b1;
            end
         end else if (do_fall) begin
            seen_rise <= 1'b0;
            if (bit_cnt == 3'h0) begin
               serial_data_out_o <= tx_data_i[7];
               tx_shift          <= {tx_data_i[6:0], 1'b1};
               tx_load_o         <= 1'b1;
            end else begin
               serial_data_out_o <= tx_shift[7];
               tx_shift          <= {tx_shift[6:0], 1'b1};
            end
         end
         serial_data_out_oe_o <= in_frame && cs_low && !paused && !cs_fall;
      end
   end

   // ------------------------------------------------------------
   // two-entry receive buffer
   // ------------------------------------------------------------
   reg       spare_v;
   reg [7:0] spare;
   wire      pop = rx_valid_o && rx_ready_i;

   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         rx_valid_o   <= 1'b0;
         rx_data_o    <= 8'h00;
         spare_v      <= 1'b0;
         spare        <= 8'h00;
         rx_overrun_o <= 1'b0;
      end else begin
         if (cs_fall)
            rx_overrun_o <= 1'b0;
         if (!rx_valid_o || pop) begin
            if (spare_v) begin
               rx_data_o  <= spare;
               rx_valid_o <= 1'b1;
               spare_v    <= push;
               if (push)
                  spare <= push_data;
            end else begin
               rx_valid_o <= push;
               if (push)
                  rx_data_o <= push_data;
            end
         end else if (push) begin
            if (!spare_v) begin
               spare   <= push_data;
               spare_v <= 1'b1;
            end else begin
               // both entries full: the incoming byte is dropped
               rx_overrun_o <= 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // execute gate and power state
   // ------------------------------------------------------------
   wire aligned   = byte_seen && (bit_cnt == 3'h0);
   wire shielded  = cmd_array_i && wp_low
                    && prot_hit(block_protect_bits_i, cmd_addr_i, cmd_bulk_i);

   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         exec_o     <= 1'b0;
         refuse_o   <= 1'b0;
         selected_o <= 1'b0;
         standby_o  <= 1'b1;
      end else begin
         exec_o     <= 1'b0;
         refuse_o   <= 1'b0;
         // one verdict per write frame, on the deselecting edge
         if (cs_rise && in_frame && armed && cmd_write_i) begin
            if (aligned && !shielded)
               exec_o <= 1'b1;
            else
               refuse_o <= 1'b1;
         end
         selected_o <= cs_low && (armed || cs_fall);
         standby_o  <= !cs_low && !busy_i;
      end
   end

endmodule // sfpi_top

/* tb/sfpi_chk_asserts.sv */
// property checks for the serial flash pin front end
`timescale 1ns/1ps
module sfpi_chk (
   input logic       clk_sys_i,
   input logic       rst_n_i,
   input logic       chip_select_n_i,
   input logic       pause_n_i,
   input logic       write_protect_n_i,
   input logic       serial_data_out_oe_o,
   input logic [7:0] rx_data_o,
   input logic       rx_valid_o,
   input logic       rx_ready_i,
   input logic       exec_o,
   input logic       refuse_o,
   input logic       cmd_array_i,
   input logic [2:0] block_protect_bits_i,
   input logic       busy_i,
   input logic       standby_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   desel_float_a: assert property (chip_select_n_i [*6] |-> !serial_data_out_oe_o)
      else $error("driven while deselected");
   pause_float_a: assert property (!pause_n_i [*6] |-> !serial_data_out_oe_o)
      else $error("driven while paused");
   idle_standby_a: assert property ((chip_select_n_i && !busy_i) [*6] |-> standby_o)
      else $error("no standby when idle");
   busy_active_a: assert property (busy_i [*2] |-> !standby_o)
      else $error("standby while busy");
   protect_all_a: assert property (exec_o && cmd_array_i && !write_protect_n_i
      |-> block_protect_bits_i < 3'h6) else $error("protected array altered");
   lone_verdict_a: assert property (exec_o |-> !refuse_o ##1 !exec_o)
      else $error("exec not a lone pulse");
   verdict_late_a: assert property (exec_o || refuse_o |-> $past(chip_select_n_i, 3))
      else $error("verdict before deselect");
   rx_hold_a: assert property (rx_valid_o && !rx_ready_i
      |=> rx_valid_o && $stable(rx_data_o)) else $error("received byte lost");
   cover property (exec_o);
   cover property (refuse_o);
   cover property ((rx_valid_o && !rx_ready_i) [*4]);
   cover property ((!pause_n_i && !chip_select_n_i) [*8]);
endmodule // sfpi_chk
bind sfpi_top sfpi_chk u_chk (.*);

/* tb/sfpi_host_model.sv */
// host side serial bus master model
`timescale 1ns/1ps
module sfpi_host_model (
   output logic sck_o,
   output logic cs_n_o,
   output logic si_o,
   output logic pause_n_o,
   input  wire  so_i
);
   logic mode3 = 1'b0;
   // chip select starts low as at power-up
   initial {sck_o, cs_n_o, si_o, pause_n_o} = 4'h3;
   task automatic burst(input [31:0] tx, input int n, pz, input bit fall, output [31:0] rx);
      rx = 0;
      sck_o = mode3;
      #37 if (fall) cs_n_o = 1'b0;
      #100;
      for (int i = n - 1; i >= 0; i--) begin
         sck_o = 1'b0;
         si_o = tx[i];
         if (i == pz) begin
            #50 pause_n_o = 1'b0;
            repeat (4) #50 {sck_o, si_o} = ~{sck_o, si_o};
            #50 pause_n_o = 1'b1;
         end
         #100 sck_o = 1'b1;
         #90 rx = {rx[30:0], so_i};
         #10;
      end
      sck_o = mode3;
      #100 cs_n_o = 1'b1;
      si_o = ~si_o;
   endtask
endmodule // sfpi_host_model

/* tb/sfpi_top_tb_top.sv */
// testbench for the serial flash pin front end
`timescale 1ns/1ps
module sfpi_top_tb_top;
   logic        clk_sys_i = 0, rst_n_i = 0, write_protect_n_i = 1, rx_ready_i = 1, busy_i = 0;
   logic        cmd_write_i = 1, cmd_array_i = 1, cmd_bulk_i = 0;
   logic [7:0]  tx_data_i = 8'hA5;
   logic [20:0] cmd_addr_i = 0;
   logic [2:0]  block_protect_bits_i = 0;
   wire         sck_i, chip_select_n_i, serial_data_in_i, pause_n_i, serial_data_out_o;
   wire         serial_data_out_oe_o, tx_load_o, rx_valid_o, rx_overrun_o, frame_end_o;
   wire         exec_o, refuse_o, selected_o, standby_o;
   wire [7:0]   rx_data_o;
   // released data line rests at its pull-up level
   wire         so_pin = serial_data_out_oe_o ? serial_data_out_o : 1'b1;
   int          n_fail = 0, compares = 0, ne = 0, nr = 0, nl = 0, nf = 0, ns = 0;
   logic [7:0]  q[$];
   logic [31:0] r;
   sfpi_top DUT (.*);
   sfpi_host_model host (.sck_o(sck_i), .cs_n_o(chip_select_n_i), .si_o(serial_data_in_i),
      .pause_n_o(pause_n_i), .so_i(so_pin));
   initial forever #12.5 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) begin
      if (rx_valid_o && rx_ready_i) q.push_back(rx_data_o);
      ne += exec_o;
      nr += refuse_o;
      nl += tx_load_o;
      nf += frame_end_o;
      ns += selected_o;
   end
   task automatic chk(input [31:0] got, input [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic t_arm;
      host.burst(32'hC3, 8, -1, 1'b0, r);
      repeat (8) @(negedge clk_sys_i);
      chk(q.size() + ne + nr, 0);
      chk(nl + nf + ns, 0);
      $display("arming test done");
   endtask
   task automatic t_buf;
      @(negedge clk_sys_i) rx_ready_i = 1'b0;
      host.burst(32'h3CC366, 24, -1, 1'b1, r);
      repeat (8) @(negedge clk_sys_i);
      chk(r, 32'hA5A5A5);
      chk({q.size(), rx_overrun_o}, 1);
      chk(nl, 4);
      chk(nf, 1);
      chk(ns, 200);
      rx_ready_i = 1'b1;
      repeat (8) @(negedge clk_sys_i);
      chk({q.size(), q[0], q[1]}, 32'h23CC3);
      $display("buffer test done");
   endtask
   task automatic t_m3;
      @(negedge clk_sys_i) {host.mode3, tx_data_i, busy_i} = {1'b1, 8'h5A, 1'b1};
      q.delete();
      host.burst(32'h81, 8, 4, 1'b1, r);
      repeat (8) @(negedge clk_sys_i);
      chk({r[7:0], q[0], standby_o}, {8'h5A, 8'h81, 1'b0});
      chk(nl, 5);
      busy_i = 1'b0;
      repeat (3) @(negedge clk_sys_i);
      chk(standby_o, 1);
      host.mode3 = 1'b0;
      $display("mode 3 pause test done");
   endtask
   task automatic t_prot;
      // [43:42] expected verdict: 2 exec, 1 refuse, 0 none
      logic [43:0] v[11] = '{44'h4_0_6_20_000000, 44'h9_0_6_20_000000, 44'h4_0_1_20_1F0000,
         44'h8_0_1_20_1EFFFF, 44'h4_0_5_20_100000, 44'h8_0_4_20_17FFFF, 44'h4_1_1_20_000000,
         44'h8_1_0_20_000000, 44'h5_0_0_0C_000000, 44'h8_2_6_20_000000, 44'h1_4_0_20_000000};
      for (int k = 0; k < 11; k++) begin
         @(negedge clk_sys_i);
         {write_protect_n_i, cmd_bulk_i, block_protect_bits_i} = {v[k][40], v[k][36], v[k][34:32]};
         {cmd_write_i, cmd_array_i, cmd_addr_i} = {!v[k][38], !v[k][37], v[k][20:0]};
         {ne, nr} = 64'h0;
         host.burst(32'h0, v[k][31:24], -1, 1'b1, r);
         repeat (8) @(negedge clk_sys_i);
         chk(2 * ne + nr, v[k][43:42]);
      end
      $display("protection test done");
   endtask
   task automatic wrap_up;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (20) @(negedge clk_sys_i);
      rst_n_i = 1'b1;
      t_arm;
      t_buf;
      t_m3;
      t_prot;
      wrap_up;
   end
   // tests need about 82 us
   initial begin
      #400000;
      n_fail++;
      wrap_up;
   end
endmodule // sfpi_top_tb_top
